// >>> verilog/rcr_clock_defs.vh
`ifndef RCR_CLOCK_DEFS_VH
`define RCR_CLOCK_DEFS_VH

// System clock
`define RCR_CLK_PERIOD_NS     10

// Frequency code is the reference frequency in steps of RCR_FREQ_STEP_HZ
`define RCR_FREQ_STEP_HZ      80
`define RCR_FREQ_W            20
`define RCR_FREQ_DEFAULT      20'd250000
`define RCR_FREQ_MIN          20'd150000
`define RCR_FREQ_MAX          20'd650000

// Auto-detection against the external low-power clock
`define RCR_LPO_KHZ_X1000     32768
`define RCR_DET_PERIODS       10'd512
`define RCR_REF_DIV           8
`define RCR_DET_TOL_SHIFT     10
`define RCR_STD_COUNT         17
`define RCR_LPO_GAP_NS        61036

// Trim, signed ppm
`define RCR_TRIM_W            8
`define RCR_TRIM_LIMIT        8'sd50
`define RCR_TRIM_RESET        8'h00

// Frequency source codes
`define RCR_SRC_DEFAULT       2'h0
`define RCR_SRC_NVM           2'h1
`define RCR_SRC_DETECT        2'h2

`endif

// >>> verilog/rcr_ref_clock_ctrl.v
`timescale 1ns/1ps
`include "rcr_clock_defs.vh"

module rcr_ref_clock_ctrl #(
   parameter [15:0] LPO_GAP_CYC = `RCR_LPO_GAP_NS / `RCR_CLK_PERIOD_NS
) (
   input  wire                          sys_clk_i,
   input  wire                          rst_n_i,
   input  wire                          por_start_i,
   input  wire                          nvm_done_i,
   input  wire                          nvm_freq_valid_i,
   input  wire [`RCR_FREQ_W-1:0]        nvm_freq_i,
   input  wire                          nvm_trim_valid_i,
   input  wire signed [`RCR_TRIM_W-1:0] nvm_trim_i,
   input  wire                          hci_trim_we_i,
   input  wire signed [`RCR_TRIM_W-1:0] hci_trim_i,
   input  wire                          low_power_oscillator_i,
   input  wire                          ref_div_i,
   input  wire                          awake_i,
   input  wire                          core_powered_i,
   input  wire                          clk_req_in_i,
   input  wire                          request_or_option_i,
   input  wire                          clk_req_enable_i,
   input  wire                          gpio_out_i,
   input  wire                          gpio_oe_n_i,
   output wire [`RCR_FREQ_W-1:0]        ref_freq_code_o,
   output wire signed [`RCR_TRIM_W-1:0] synth_trim_o,
   output wire [1:0]                    freq_source_o,
   output wire                          cfg_busy_o,
   output wire                          timing_valid_o,
   output wire                          timebase_lpo_o,
   output wire                          lpo_ext_sel_o,
   output wire                          clk_req_pin_o,
   output wire                          clk_req_pin_oe_n_o
);

   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_NVM   = 3'h1;
   localparam [2:0] S_SYNC  = 3'h2;
   localparam [2:0] S_MEAS  = 3'h3;
   localparam [2:0] S_MATCH = 3'h4;
   localparam [2:0] S_DONE  = 3'h5;

   // Standard handset reference frequencies in kHz
   function [15:0] std_khz;
      input [4:0] idx;
      begin
         case (idx)
            5'h00:   std_khz = 16'd12000;
            5'h01:   std_khz = 16'd13000;
            5'h02:   std_khz = 16'd14400;
            5'h03:   std_khz = 16'd15360;
            5'h04:   std_khz = 16'd16200;
            5'h05:   std_khz = 16'd16800;
            5'h06:   std_khz = 16'd18000;
            5'h07:   std_khz = 16'd19200;
            5'h08:   std_khz = 16'd19440;
            5'h09:   std_khz = 16'd19680;
            5'h0A:   std_khz = 16'd19800;
            5'h0B:   std_khz = 16'd20000;
            5'h0C:   std_khz = 16'd24000;
            5'h0D:   std_khz = 16'd26000;
            5'h0E:   std_khz = 16'd33600;
            5'h0F:   std_khz = 16'd37400;
            5'h10:   std_khz = 16'd38400;
            default: std_khz = 16'd0;
         endcase
      end
   endfunction

   // Limit a trim value to the supported correction range
   function signed [`RCR_TRIM_W-1:0] clamp_trim;
      input signed [`RCR_TRIM_W-1:0] t;
      begin
         if (t > `RCR_TRIM_LIMIT)
            clamp_trim = `RCR_TRIM_LIMIT;
         else if (t < -`RCR_TRIM_LIMIT)
            clamp_trim = -`RCR_TRIM_LIMIT;
         else
            clamp_trim = t;
      end
   endfunction

   reg [2:0]                    state_reg;
   reg [2:0]                    state_next;
   reg [`RCR_FREQ_W-1:0]        freq_reg;
   reg [`RCR_FREQ_W-1:0]        freq_next;
   reg [1:0]                    src_reg;
   reg [1:0]                    src_next;
   reg signed [`RCR_TRIM_W-1:0] trim_reg;
   reg signed [`RCR_TRIM_W-1:0] trim_next;
   reg                          lpo_d_reg;
   reg                          ref_d_reg;
   reg [9:0]                    per_cnt_reg;
   reg [9:0]                    per_cnt_next;
   reg [17:0]                   ref_cnt_reg;
   reg [17:0]                   ref_cnt_next;
   reg [15:0]                   gap_cnt_reg;
   reg [15:0]                   gap_cnt_next;
   reg [4:0]                    idx_reg;
   reg [4:0]                    idx_next;
   reg                          lpo_ok_reg;
   reg                          lpo_ok_next;
   reg                          busy_reg;
   reg                          valid_reg;
   reg                          tb_lpo_reg;
   reg                          lpo_ext_reg;
   reg                          pin_reg;
   reg                          pin_oe_n_reg;

   wire        lpo_rise  = low_power_oscillator_i & ~lpo_d_reg;
   wire        ref_rise  = ref_div_i & ~ref_d_reg;
   wire        gap_over  = (gap_cnt_reg >= LPO_GAP_CYC);
   wire [31:0] exp_wide  = ({16'h0000, std_khz(idx_reg)} * 32'd125) >> 6;
   wire [17:0] exp_cnt   = exp_wide[17:0];
   wire [17:0] tol_cnt   = exp_cnt >> `RCR_DET_TOL_SHIFT;
   wire [17:0] diff_cnt  = (ref_cnt_reg >= exp_cnt) ? (ref_cnt_reg - exp_cnt)
                                                    : (exp_cnt - ref_cnt_reg);
   wire [31:0] khz_code  = ({16'h0000, std_khz(idx_reg)} * 32'd25) >> 1;
   wire        nvm_in_rng = (nvm_freq_i >= `RCR_FREQ_MIN) && (nvm_freq_i <= `RCR_FREQ_MAX);
   wire        int_req   = awake_i & core_powered_i;

   // Power-on frequency selection sequence
   always @* begin
      state_next   = state_reg;
      freq_next    = freq_reg;
      src_next     = src_reg;
      trim_next    = trim_reg;
      per_cnt_next = per_cnt_reg;
      ref_cnt_next = ref_cnt_reg;
      gap_cnt_next = gap_cnt_reg;
      idx_next     = idx_reg;
      lpo_ok_next  = lpo_ok_reg;
      if (state_reg == S_SYNC || state_reg == S_MEAS) begin
         if (lpo_rise)
            gap_cnt_next = 16'h0000;
         else if (!gap_over)
            gap_cnt_next = gap_cnt_reg + 16'h0001;
      end
      case (state_reg)
         S_IDLE: begin
            if (por_start_i) begin
               freq_next  = `RCR_FREQ_DEFAULT;
               src_next   = `RCR_SRC_DEFAULT;
               state_next = S_NVM;
            end
         end
         S_NVM: begin
            if (nvm_done_i) begin
               if (nvm_trim_valid_i)
                  trim_next = clamp_trim(nvm_trim_i);
               if (nvm_freq_valid_i && nvm_in_rng) begin
                  freq_next  = nvm_freq_i;
                  src_next   = `RCR_SRC_NVM;
                  state_next = S_DONE;
               end else begin
                  gap_cnt_next = 16'h0000;
                  state_next   = S_SYNC;
               end
            end
         end
         S_SYNC: begin
            if (lpo_rise) begin
               lpo_ok_next  = 1'b1;
               per_cnt_next = 10'h000;
               ref_cnt_next = 18'h00000;
               state_next   = S_MEAS;
            end else if (gap_over) begin
               lpo_ok_next = 1'b0;
               state_next  = S_DONE;
            end
         end
         S_MEAS: begin
            if (ref_rise)
               ref_cnt_next = ref_cnt_reg + 18'h00001;
            if (gap_over) begin
               lpo_ok_next = 1'b0;
               state_next  = S_DONE;
            end else if (lpo_rise) begin
               per_cnt_next = per_cnt_reg + 10'h001;
               if (per_cnt_reg == `RCR_DET_PERIODS - 10'h001) begin
                  idx_next   = 5'h00;
                  state_next = S_MATCH;
               end
            end
         end
         S_MATCH: begin
            if (diff_cnt <= tol_cnt) begin
               freq_next  = khz_code[`RCR_FREQ_W-1:0];
               src_next   = `RCR_SRC_DETECT;
               state_next = S_DONE;
            end else if (idx_reg == `RCR_STD_COUNT - 1) begin
               state_next = S_DONE;
            end else begin
               idx_next = idx_reg + 5'h01;
            end
         end
         S_DONE: begin
            if (por_start_i) begin
               freq_next  = `RCR_FREQ_DEFAULT;
               src_next   = `RCR_SRC_DEFAULT;
               state_next = S_NVM;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
      if (hci_trim_we_i)
         trim_next = clamp_trim(hci_trim_i);
   end

   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg   <= S_IDLE;
         freq_reg    <= `RCR_FREQ_DEFAULT;
         src_reg     <= `RCR_SRC_DEFAULT;
         trim_reg    <= `RCR_TRIM_RESET;
         lpo_d_reg   <= 1'b0;
         ref_d_reg   <= 1'b0;
         per_cnt_reg <= 10'h000;
         ref_cnt_reg <= 18'h00000;
         gap_cnt_reg <= 16'h0000;
         idx_reg     <= 5'h00;
         lpo_ok_reg  <= 1'b0;
      end else begin
         state_reg   <= state_next;
         freq_reg    <= freq_next;
         src_reg     <= src_next;
         trim_reg    <= trim_next;
         lpo_d_reg   <= low_power_oscillator_i;
         ref_d_reg   <= ref_div_i;
         per_cnt_reg <= per_cnt_next;
         ref_cnt_reg <= ref_cnt_next;
         gap_cnt_reg <= gap_cnt_next;
         idx_reg     <= idx_next;
         lpo_ok_reg  <= lpo_ok_next;
      end
   end

   // Status, timebase and clock request pin
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_reg     <= 1'b0;
         valid_reg    <= 1'b0;
         tb_lpo_reg   <= 1'b0;
         lpo_ext_reg  <= 1'b0;
         pin_reg      <= 1'b0;
         pin_oe_n_reg <= 1'b1;
      end else begin
         busy_reg    <= (state_next != S_IDLE) && (state_next != S_DONE);
         valid_reg   <= (state_next == S_DONE);
         tb_lpo_reg  <= ~awake_i;
         lpo_ext_reg <= lpo_ok_next;
         if (clk_req_enable_i) begin
            pin_oe_n_reg <= 1'b0;
            if (request_or_option_i)
               pin_reg <= clk_req_in_i | int_req;
            else
               pin_reg <= int_req;
         end else begin
            pin_reg      <= gpio_out_i;
            pin_oe_n_reg <= gpio_oe_n_i;
         end
      end
   end

   assign ref_freq_code_o    = freq_reg;
   assign synth_trim_o       = trim_reg;
   assign freq_source_o      = src_reg;
   assign cfg_busy_o         = busy_reg;
   assign timing_valid_o     = valid_reg;
   assign timebase_lpo_o     = tb_lpo_reg;
   assign lpo_ext_sel_o      = lpo_ext_reg;
   assign clk_req_pin_o      = pin_reg;
   assign clk_req_pin_oe_n_o = pin_oe_n_reg;

endmodule // rcr_ref_clock_ctrl

// >>> tb/rcr_monitor.sv
`timescale 1ns/1ps
`include "rcr_clock_defs.vh"
module rcr_monitor (
   input wire                          sys_clk_i, rst_n_i, por_start_i, nvm_done_i,
   input wire                          nvm_freq_valid_i, hci_trim_we_i, awake_i, core_powered_i,
   input wire                          clk_req_in_i, request_or_option_i, clk_req_enable_i,
   input wire                          gpio_out_i, gpio_oe_n_i, cfg_busy_o, timing_valid_o,
   input wire                          timebase_lpo_o, clk_req_pin_o, clk_req_pin_oe_n_o,
   input wire [1:0]                    freq_source_o,
   input wire [`RCR_FREQ_W-1:0]        nvm_freq_i, ref_freq_code_o,
   input wire signed [`RCR_TRIM_W-1:0] hci_trim_i, synth_trim_o
);
   reg wait_nvm_reg;
   // Tracks the window in which a memory load is taken
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         wait_nvm_reg <= 1'b0;
      else if (por_start_i && !cfg_busy_o)
         wait_nvm_reg <= 1'b1;
      else if (nvm_done_i)
         wait_nvm_reg <= 1'b0;
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_start;
      por_start_i && !cfg_busy_o |=> cfg_busy_o && !timing_valid_o;
   endproperty
   a_start: assert property (p_start)
      else $error("busy did not rise");
   property p_nvm;
      wait_nvm_reg && nvm_done_i && nvm_freq_valid_i && nvm_freq_i >= `RCR_FREQ_MIN &&
      nvm_freq_i <= `RCR_FREQ_MAX |=> ref_freq_code_o == $past(nvm_freq_i) &&
      freq_source_o == `RCR_SRC_NVM ##1 !cfg_busy_o && timing_valid_o;
   endproperty
   a_nvm: assert property (p_nvm)
      else $error("memory frequency not applied");
   property p_range;
      freq_source_o == `RCR_SRC_NVM |->
      ref_freq_code_o >= `RCR_FREQ_MIN && ref_freq_code_o <= `RCR_FREQ_MAX;
   endproperty
   a_range: assert property (p_range)
      else $error("memory frequency out of range");
   property p_trim;
      synth_trim_o <= `RCR_TRIM_LIMIT && synth_trim_o >= -`RCR_TRIM_LIMIT;
   endproperty
   a_trim: assert property (p_trim)
      else $error("trim beyond limit");
   property p_hci;
      hci_trim_we_i && hci_trim_i <= `RCR_TRIM_LIMIT && hci_trim_i >= -`RCR_TRIM_LIMIT
      |=> synth_trim_o == $past(hci_trim_i);
   endproperty
   a_hci: assert property (p_hci)
      else $error("host trim not applied");
   property p_awake;
      clk_req_enable_i && !request_or_option_i && core_powered_i
      |=> clk_req_pin_o == $past(awake_i) && !clk_req_pin_oe_n_o;
   endproperty
   a_awake: assert property (p_awake)
      else $error("request does not follow awake");
   property p_or;
      clk_req_enable_i && request_or_option_i
      |=> clk_req_pin_o == $past(clk_req_in_i | (awake_i & core_powered_i));
   endproperty
   a_or: assert property (p_or)
      else $error("combined request wrong");
   property p_gpio;
      !clk_req_enable_i |=> clk_req_pin_o == $past(gpio_out_i) &&
      clk_req_pin_oe_n_o == $past(gpio_oe_n_i);
   endproperty
   a_gpio: assert property (p_gpio)
      else $error("pin not released to general use");
   property p_timebase;
      $past(rst_n_i) |-> timebase_lpo_o == !$past(awake_i);
   endproperty
   a_timebase: assert property (p_timebase)
      else $error("timebase wrong");
   property p_hold;
      timing_valid_o && !por_start_i |=> timing_valid_o && $stable(ref_freq_code_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("configured frequency moved");
endmodule // rcr_monitor
bind rcr_ref_clock_ctrl rcr_monitor mon_u (.*);

// >>> tb/rcr_osc_model.sv
`timescale 1ns/1ps
module rcr_osc_model #(
   parameter integer LPO_HIGH = 91,
   parameter integer LPO_LOW  = 92
) (
   input  wire sys_clk_i,
   input  wire run_i,
   output reg  lpo_o,
   output reg  ref_div_o
);
   reg [1:0] div_cnt;
   integer   lpo_cnt;
   initial begin
      lpo_o = 1'b0;
      ref_div_o = 1'b0;
      div_cnt = 2'h0;
      lpo_cnt = 0;
   end
   // Divided reference, period 4 cycles, in fixed ratio to the slow clock
   always @(negedge sys_clk_i) begin
      div_cnt <= div_cnt + 2'h1;
      ref_div_o <= div_cnt[1];
      if (!run_i) begin
         lpo_o <= 1'b0;
         lpo_cnt <= 0;
      end else if (lpo_cnt == (lpo_o ? LPO_HIGH : LPO_LOW) - 1) begin
         lpo_o <= ~lpo_o;
         lpo_cnt <= 0;
      end else
         lpo_cnt <= lpo_cnt + 1;
   end
endmodule // rcr_osc_model

// >>> tb/rcr_ref_clock_ctrl_test.sv
`timescale 1ns/1ps
`include "rcr_clock_defs.vh"
module rcr_ref_clock_ctrl_test;
   reg              sys_clk_i, rst_n_i, por_start_i, nvm_done_i, nvm_freq_valid_i;
   reg              nvm_trim_valid_i, hci_trim_we_i, awake_i, core_powered_i, clk_req_in_i;
   reg              request_or_option_i, clk_req_enable_i, gpio_out_i, gpio_oe_n_i, osc_run;
   reg [19:0]       nvm_freq_i;
   reg [7:0]        nvm_trim_i, hci_trim_i;
   reg [9:0]        row;
   wire             low_power_oscillator, ref_div, busy, valid, tb_lpo, ext_sel, pin, oe_n;
   wire [19:0]      freq;
   wire [7:0]       trim;
   wire [1:0]       src;
   integer          failures, checks, i, k;
   localparam [99:0] PIN_ROWS = {10'h349, 10'h3CC, 10'h36D, 10'h3EC, 10'h388,
                                 10'h3AC, 10'h269, 10'h2CC, 10'h16B, 10'h0D4};
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   rcr_osc_model osc_u (.sys_clk_i(sys_clk_i), .run_i(osc_run), .lpo_o(low_power_oscillator), .ref_div_o(ref_div));
   rcr_ref_clock_ctrl #(.LPO_GAP_CYC(16'd200)) dut_u (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .por_start_i(por_start_i),
      .nvm_done_i(nvm_done_i), .nvm_freq_valid_i(nvm_freq_valid_i), .nvm_freq_i(nvm_freq_i),
      .nvm_trim_valid_i(nvm_trim_valid_i), .nvm_trim_i(nvm_trim_i),
      .hci_trim_we_i(hci_trim_we_i), .hci_trim_i(hci_trim_i), .low_power_oscillator_i(low_power_oscillator),
      .ref_div_i(ref_div), .awake_i(awake_i), .core_powered_i(core_powered_i),
      .clk_req_in_i(clk_req_in_i), .request_or_option_i(request_or_option_i),
      .clk_req_enable_i(clk_req_enable_i), .gpio_out_i(gpio_out_i), .gpio_oe_n_i(gpio_oe_n_i),
      .ref_freq_code_o(freq), .synth_trim_o(trim), .freq_source_o(src), .cfg_busy_o(busy),
      .timing_valid_o(valid), .timebase_lpo_o(tb_lpo), .lpo_ext_sel_o(ext_sel),
      .clk_req_pin_o(pin), .clk_req_pin_oe_n_o(oe_n));
   task summarize;
      begin
         if (failures == 0 && checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task chk_val(input [19:0] got, input [19:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task chk_flag(input got, input exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task start_sel(input fv, input [19:0] f, input tv, input [7:0] t);
      begin
         @(negedge sys_clk_i) por_start_i = 1'b1;
         @(negedge sys_clk_i) por_start_i = 1'b0;
         chk_flag(busy, 1'b1);
         chk_flag(valid, 1'b0);
         {nvm_done_i, nvm_freq_valid_i, nvm_freq_i} = {1'b1, fv, f};
         {nvm_trim_valid_i, nvm_trim_i} = {tv, t};
         @(negedge sys_clk_i) nvm_done_i = 1'b0;
      end
   endtask
   task wait_idle(input integer n);
      begin
         k = 0;
         while (busy === 1'b1 && k < n) begin
            @(negedge sys_clk_i) k = k + 1;
         end
         if (k >= n) begin
            failures = failures + 1;
            summarize;
         end
      end
   endtask
   task hci(input [7:0] t);
      begin
         @(negedge sys_clk_i) {hci_trim_we_i, hci_trim_i} = {1'b1, t};
         @(negedge sys_clk_i) hci_trim_we_i = 1'b0;
      end
   endtask
   initial begin
      {rst_n_i, por_start_i, nvm_done_i, nvm_freq_valid_i, nvm_trim_valid_i, hci_trim_we_i} = 6'h00;
      {awake_i, core_powered_i, request_or_option_i, clk_req_enable_i, gpio_out_i} = 5'h02;
      {gpio_oe_n_i, osc_run, nvm_freq_i, nvm_trim_i, hci_trim_i} = {2'h2, 20'h00000, 16'h0000};
      clk_req_in_i = 1'b0;
      failures = 0;
      checks = 0;
      repeat (10) @(negedge sys_clk_i);
      chk_val(freq, `RCR_FREQ_DEFAULT);
      chk_val({18'h00000, src}, 20'h00000);
      chk_val({12'h000, trim}, 20'h00000);
      chk_flag(oe_n, 1'b1);
      rst_n_i = 1'b1;
      for (i = 0; i < 10; i = i + 1) begin
         row = PIN_ROWS[99-10*i -: 10];
         @(negedge sys_clk_i) {clk_req_enable_i, request_or_option_i, awake_i, core_powered_i,
                               clk_req_in_i, gpio_out_i, gpio_oe_n_i} = row[9:3];
         @(negedge sys_clk_i) chk_flag(pin, row[2]);
         chk_flag(oe_n, row[1]);
         chk_flag(tb_lpo, row[0]);
      end
      // Memory wins even with the slow clock running
      osc_run = 1'b1;
      start_sel(1'b1, 20'h30D40, 1'b1, 8'h14);
      wait_idle(50);
      chk_val(freq, 20'h30D40);
      chk_val({18'h00000, src}, 20'h00001);
      chk_val({12'h000, trim}, 20'h00014);
      chk_flag(valid, 1'b1);
      // Out-of-range memory value, no slow clock: default stays
      osc_run = 1'b0;
      start_sel(1'b1, 20'h186A0, 1'b1, 8'hB0);
      wait_idle(600);
      chk_val(freq, 20'h3D090);
      chk_val({18'h00000, src}, 20'h00000);
      chk_val({12'h000, trim}, 20'h000CE);
      chk_flag(ext_sel, 1'b0);
      chk_flag(valid, 1'b1);
      hci(8'h46);
      @(negedge sys_clk_i) chk_val({12'h000, trim}, 20'h00032);
      hci(8'hF3);
      @(negedge sys_clk_i) chk_val({12'h000, trim}, 20'h000F3);
      // Detection of a 12 MHz reference
      osc_run = 1'b1;
      start_sel(1'b0, 20'h00000, 1'b0, 8'h00);
      wait_idle(96000);
      chk_val(freq, 20'h249F0);
      chk_val({18'h00000, src}, 20'h00002);
      chk_flag(ext_sel, 1'b1);
      summarize;
   end
endmodule // rcr_ref_clock_ctrl_test
